// [verilog/srs_pkg.sv]
// Package: constants and types of the service request init sequencer
`default_nettype none
package srs_pkg;

localparam int DEV_AW = 20;
localparam int DW     = 32;
localparam int SW_AW  = 8;
localparam int PEND_W = 16;
localparam int PORTS  = 32;

// Device register offsets
localparam logic [DEV_AW-1:0] DEV_SOFT_RST = 20'h00000;
localparam logic [DEV_AW-1:0] DEV_IQ_BASE  = 20'h00004;
localparam logic [DEV_AW-1:0] DEV_IQ_LEN   = 20'h00008;
localparam logic [DEV_AW-1:0] DEV_TX_ALIVE = 20'h0000C;
localparam logic [DEV_AW-1:0] DEV_RX_ALIVE = 20'h00010;
localparam logic [DEV_AW-1:0] DEV_REQ_PTR  = 20'h00014;
localparam logic [DEV_AW-1:0] DEV_REQ_LEN  = 20'h00018;
localparam logic [DW-1:0]     SOFT_RST_VAL = 32'h00000001;

// Controller register offsets
localparam logic [SW_AW-1:0] R_CTRL    = 8'h00;
localparam logic [SW_AW-1:0] R_IQ_BASE = 8'h04;
localparam logic [SW_AW-1:0] R_IQ_LEN  = 8'h08;
localparam logic [SW_AW-1:0] R_TBL_PTR = 8'h0C;
localparam logic [SW_AW-1:0] R_TBL_LEN = 8'h10;
localparam logic [SW_AW-1:0] R_TX_MASK = 8'h14;
localparam logic [SW_AW-1:0] R_RX_MASK = 8'h18;
localparam logic [SW_AW-1:0] R_STATUS  = 8'h1C;
localparam logic [SW_AW-1:0] R_PENDING = 8'h20;
localparam logic [SW_AW-1:0] R_TX_SEEN = 8'h24;
localparam logic [SW_AW-1:0] R_RX_SEEN = 8'h28;

// Control and status bit positions
localparam int CTRL_INIT   = 0;
localparam int CTRL_SOFT   = 1;
localparam int CTRL_SUBMIT = 2;
localparam int ST_NOCLK    = 3;
localparam int ST_ERR      = 4;

// Serial wait between alive polls
localparam int CLK_NS         = 20;
localparam int SER_CLK_NS     = 1000;
localparam int SER_WAIT_CLKS  = 16;
localparam int ALIVE_WAIT_CYC = (SER_WAIT_CLKS * SER_CLK_NS + CLK_NS - 1) / CLK_NS;
localparam int NOCLK_SYS_CLKS = 16;

typedef enum logic [3:0] {
    S_IDLE       = 4'h0,
    S_RST_WR     = 4'h1,
    S_INIT_POLL  = 4'h2,
    S_IQB_WR     = 4'h3,
    S_IQL_WR     = 4'h4,
    S_TXA_RD     = 4'h5,
    S_RXA_RD     = 4'h6,
    S_ALIVE_WAIT = 4'h7,
    S_PTR_WR     = 4'h8,
    S_LEN_WR     = 4'h9,
    S_DONE_POLL  = 4'hA
} srs_state_e;

typedef struct packed {
    logic              rd;
    logic              wr;
    logic [DEV_AW-1:0] addr;
    logic [DW-1:0]     wdata;
} srs_dev_req_s;

typedef struct packed {
    logic             rd;
    logic             wr;
    logic [SW_AW-1:0] addr;
    logic [DW-1:0]    wdata;
} srs_sw_req_s;
endpackage
`default_nettype wire

// [verilog/srs_host_seq.sv]
// Host-side start-up and request table sequencer for the serial-link device
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module srs_host_seq
    import srs_pkg::*;
#(
    parameter int WAIT_CYC = ALIVE_WAIT_CYC
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    // Software register port
    input  wire srs_sw_req_s  sw_req,
    output var  logic [DW-1:0] sw_rdata,
    // Device register access
    output var  srs_dev_req_s dev_req,
    input  wire logic [DW-1:0] dev_rdata
);

    srs_state_e        state_q, state_d;
    srs_dev_req_s      dev_req_q, dev_req_d;
    logic [1:0]        step_q;
    logic [15:0]       wait_q;
    logic              submit_q;
    logic              soft_en_q;
    logic              miss_q;
    logic [7:0]        miss_age_q;
    logic              init_done_q;
    logic              tbl_done_q;
    logic              noclk_q;
    logic              err_q;
    logic [DW-1:0]     iq_base_q;
    logic [DW-1:0]     iq_len_q;
    logic [DW-1:0]     tbl_ptr_q;
    logic [PEND_W-1:0] tbl_len_q;
    logic [PORTS-1:0]  tx_mask_q;
    logic [PORTS-1:0]  rx_mask_q;
    logic [PORTS-1:0]  tx_seen_q;
    logic [PORTS-1:0]  rx_seen_q;
    logic [PEND_W-1:0] pend_q;
    logic [DW-1:0]     sw_rdata_q, sw_rdata_d;

    // Register decode
    wire busy     = (state_q != S_IDLE);
    wire wr_ctrl  = sw_req.wr && (sw_req.addr == R_CTRL);
    wire wr_stat  = sw_req.wr && (sw_req.addr == R_STATUS);
    wire go_init  = wr_ctrl && sw_req.wdata[CTRL_INIT] && !busy;
    wire go_sub   = wr_ctrl && sw_req.wdata[CTRL_SUBMIT] && !busy;
    wire go_late  = wr_ctrl && (sw_req.wdata[CTRL_INIT] || sw_req.wdata[CTRL_SUBMIT]) && busy;
    wire rd_data  = (step_q == 2'd2);
    wire rd_issue = (step_q == 2'd0);
    wire is_read  = (state_q == S_INIT_POLL) || (state_q == S_TXA_RD) ||
                    (state_q == S_RXA_RD) || (state_q == S_DONE_POLL);
    wire pend_zero = (dev_rdata[PEND_W-1:0] == '0);
    wire tx_ok    = ((dev_rdata[PORTS-1:0] & tx_mask_q) == tx_mask_q);
    wire rx_ok    = ((dev_rdata[PORTS-1:0] & rx_mask_q) == rx_mask_q);
    wire alive_miss = rd_data && (((state_q == S_TXA_RD) && !tx_ok) ||
                                  ((state_q == S_RXA_RD) && !rx_ok));
    wire noclk_hit = alive_miss && miss_q && (miss_age_q == 8'(NOCLK_SYS_CLKS));

    // Sequencer: every device access is one strobe from a flop
    always_comb begin
        state_d   = state_q;
        dev_req_d = '0;
        case (state_q)
            S_IDLE: begin
                if (go_init) begin
                    state_d = sw_req.wdata[CTRL_SOFT] ? S_RST_WR : S_INIT_POLL;
                end else if (go_sub) begin
                    state_d = S_INIT_POLL;
                end
            end
            S_RST_WR: begin
                dev_req_d.wr    = 1'b1;
                dev_req_d.addr  = DEV_SOFT_RST;
                dev_req_d.wdata = SOFT_RST_VAL;
                state_d         = S_INIT_POLL;
            end
            S_INIT_POLL: begin
                dev_req_d.rd   = rd_issue;
                dev_req_d.addr = DEV_REQ_LEN;
                if (rd_data && pend_zero) begin
                    state_d = submit_q ? S_PTR_WR : S_IQB_WR;
                end
            end
            S_IQB_WR: begin
                dev_req_d.wr    = 1'b1;
                dev_req_d.addr  = DEV_IQ_BASE;
                dev_req_d.wdata = iq_base_q;
                state_d         = S_IQL_WR;
            end
            S_IQL_WR: begin
                dev_req_d.wr    = 1'b1;
                dev_req_d.addr  = DEV_IQ_LEN;
                dev_req_d.wdata = iq_len_q;
                state_d         = S_TXA_RD;
            end
            S_TXA_RD: begin
                dev_req_d.rd   = rd_issue;
                dev_req_d.addr = DEV_TX_ALIVE;
                if (rd_data) begin
                    state_d = tx_ok ? S_RXA_RD : S_ALIVE_WAIT;
                end
            end
            S_RXA_RD: begin
                dev_req_d.rd   = rd_issue;
                dev_req_d.addr = DEV_RX_ALIVE;
                if (rd_data) begin
                    state_d = rx_ok ? S_IDLE : S_ALIVE_WAIT;
                end
            end
            S_ALIVE_WAIT: begin
                if (wait_q == '0) begin
                    state_d = S_TXA_RD;
                end
            end
            S_PTR_WR: begin
                dev_req_d.wr    = 1'b1;
                dev_req_d.addr  = DEV_REQ_PTR;
                dev_req_d.wdata = tbl_ptr_q;
                state_d         = S_LEN_WR;
            end
            S_LEN_WR: begin
                dev_req_d.wr    = 1'b1;
                dev_req_d.addr  = DEV_REQ_LEN;
                dev_req_d.wdata = {{(DW-PEND_W){1'b0}}, tbl_len_q};
                state_d         = S_DONE_POLL;
            end
            S_DONE_POLL: begin
                dev_req_d.rd   = rd_issue;
                dev_req_d.addr = DEV_REQ_LEN;
                if (rd_data && pend_zero) begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    // State, strobes and read phase
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q   <= S_IDLE;
            dev_req_q <= '0;
            step_q    <= 2'd0;
        end else begin
            state_q   <= state_d;
            dev_req_q <= dev_req_d;
            step_q    <= (is_read && !rd_data) ? step_q + 2'd1 : 2'd0;
        end
    end

    // Serial wait timer, loaded on every failed alive check
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= '0;
        end else if (alive_miss) begin
            wait_q <= 16'(WAIT_CYC - 1);
        end else if (wait_q != '0) begin
            wait_q <= wait_q - 16'd1;
        end
    end

    // Age since the first failed alive check; a short wait alone must not flag
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            miss_age_q <= '0;
        end else if (!miss_q) begin
            miss_age_q <= '0;
        end else if (miss_age_q != 8'(NOCLK_SYS_CLKS)) begin
            miss_age_q <= miss_age_q + 8'd1;
        end
    end

    // Mode and sticky flags; hardware set beats software clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            submit_q    <= 1'b0;
            soft_en_q   <= 1'b0;
            miss_q      <= 1'b0;
            noclk_q     <= 1'b0;
            err_q       <= 1'b0;
            init_done_q <= 1'b0;
            tbl_done_q  <= 1'b0;
        end else begin
            if (go_init || go_sub) begin
                submit_q <= go_sub;
            end
            if (go_init) begin
                soft_en_q   <= sw_req.wdata[CTRL_SOFT];
                init_done_q <= 1'b0;
            end else if ((state_q == S_RXA_RD) && rd_data && rx_ok) begin
                init_done_q <= 1'b1;
            end
            if (go_sub) begin
                tbl_done_q <= 1'b0;
            end else if ((state_q == S_DONE_POLL) && rd_data && pend_zero) begin
                tbl_done_q <= 1'b1;
            end
            // A miss once the age limit is reached means no serial clock
            if (state_q == S_IQL_WR) begin
                miss_q <= 1'b0;
            end else if (alive_miss) begin
                miss_q <= 1'b1;
            end
            if (noclk_hit) begin
                noclk_q <= 1'b1;
            end else if (wr_stat && sw_req.wdata[ST_NOCLK]) begin
                noclk_q <= 1'b0;
            end
            // Starting a new table while busy is dropped, as the device may do
            if (go_late) begin
                err_q <= 1'b1;
            end else if (wr_stat && sw_req.wdata[ST_ERR]) begin
                err_q <= 1'b0;
            end
        end
    end

    // Captured device status
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q    <= '0;
            tx_seen_q <= '0;
            rx_seen_q <= '0;
        end else if (rd_data) begin
            if ((state_q == S_INIT_POLL) || (state_q == S_DONE_POLL)) begin
                pend_q <= dev_rdata[PEND_W-1:0];
            end
            if (state_q == S_TXA_RD) begin
                tx_seen_q <= dev_rdata[PORTS-1:0];
            end
            if (state_q == S_RXA_RD) begin
                rx_seen_q <= dev_rdata[PORTS-1:0];
            end
        end
    end

    // Software settings, held while a sequence runs
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            iq_base_q <= '0;
            iq_len_q  <= '0;
            tbl_ptr_q <= '0;
            tbl_len_q <= '0;
            tx_mask_q <= '0;
            rx_mask_q <= '0;
        end else if (sw_req.wr && !busy) begin
            case (sw_req.addr)
                R_IQ_BASE: iq_base_q <= sw_req.wdata;
                R_IQ_LEN:  iq_len_q  <= sw_req.wdata;
                R_TBL_PTR: tbl_ptr_q <= sw_req.wdata;
                R_TBL_LEN: tbl_len_q <= sw_req.wdata[PEND_W-1:0];
                R_TX_MASK: tx_mask_q <= sw_req.wdata[PORTS-1:0];
                R_RX_MASK: rx_mask_q <= sw_req.wdata[PORTS-1:0];
                default:   ;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        sw_rdata_d = '0;
        case (sw_req.addr)
            R_CTRL:    sw_rdata_d = {30'h0, soft_en_q, 1'b0};
            R_IQ_BASE: sw_rdata_d = iq_base_q;
            R_IQ_LEN:  sw_rdata_d = iq_len_q;
            R_TBL_PTR: sw_rdata_d = tbl_ptr_q;
            R_TBL_LEN: sw_rdata_d = {{(DW-PEND_W){1'b0}}, tbl_len_q};
            R_TX_MASK: sw_rdata_d = tx_mask_q;
            R_RX_MASK: sw_rdata_d = rx_mask_q;
            R_STATUS:  sw_rdata_d = {20'h0, state_q, 3'h0, err_q, noclk_q,
                                     tbl_done_q, init_done_q, busy};
            R_PENDING: sw_rdata_d = {{(DW-PEND_W){1'b0}}, pend_q};
            R_TX_SEEN: sw_rdata_d = tx_seen_q;
            R_RX_SEEN: sw_rdata_d = rx_seen_q;
            default:   sw_rdata_d = '0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_rdata_q <= '0;
        end else begin
            sw_rdata_q <= sw_req.rd ? sw_rdata_d : '0;
        end
    end

    assign sw_rdata = sw_rdata_q;
    assign dev_req  = dev_req_q;

    // Checks on the device-facing sequence
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_zero_seen;
        rd_data && pend_zero && (state_q == S_INIT_POLL);
    endsequence

    sequence s_ptr_then_len;
        dev_req.wr && (dev_req.addr == DEV_REQ_PTR) ##1
        dev_req.wr && (dev_req.addr == DEV_REQ_LEN);
    endsequence

    strobe_excl_a: assert property (!(dev_req.rd && dev_req.wr))
        else $error("device read and write strobes together");
    soft_rst_wr_a: assert property ((state_q == S_RST_WR) |=>
        dev_req.wr && (dev_req.addr == DEV_SOFT_RST) && (dev_req.wdata == SOFT_RST_VAL))
        else $error("soft reset write missing");
    iq_after_init_a: assert property ((s_zero_seen and !submit_q) |=> ##1
        dev_req.wr && (dev_req.addr == DEV_IQ_BASE) ##1 dev_req.addr == DEV_IQ_LEN)
        else $error("queue setup not after zero pending");
    ptr_before_len_a: assert property (dev_req.wr && (dev_req.addr == DEV_REQ_LEN) |->
        $past(dev_req.wr) && ($past(dev_req.addr) == DEV_REQ_PTR))
        else $error("length written without pointer");
    len_value_a: assert property (s_ptr_then_len |->
        dev_req.wdata[PEND_W-1:0] == tbl_len_q)
        else $error("wrong table length written");
    done_zero_a: assert property ($rose(tbl_done_q) |-> pend_q == '0)
        else $error("table done with entries pending");
    alive_wait_a: assert property ($rose(state_q == S_ALIVE_WAIT) |->
        (state_q == S_ALIVE_WAIT)[*8])
        else $error("alive wait too short");
    noclk_flag_a: assert property (noclk_hit |=> noclk_q)
        else $error("missing serial clock not flagged");
    late_go_a: assert property (go_late |=> err_q && $stable(tbl_ptr_q))
        else $error("start while busy not refused");
    read_pulse_a: assert property (dev_req.rd |=> !dev_req.rd ##1 !dev_req.rd)
        else $error("device read strobe longer than one cycle");
    // Read port, no-clock, alive wait and table-done timing
    noclk_age_a: assert property ($rose(noclk_q) |->
        miss_age_q == 8'(NOCLK_SYS_CLKS))
        else $error("no-clock flag before age limit");
    rdata_idle_a: assert property (!$past(sw_req.rd) |-> sw_rdata == '0)
        else $error("read data outside its cycle");
    wait_load_a: assert property (alive_miss |=> (state_q == S_ALIVE_WAIT) &&
        (wait_q == 16'(WAIT_CYC - 1)))
        else $error("alive wait not loaded");
    done_poll_a: assert property ($rose(tbl_done_q) |-> $past(state_q) == S_DONE_POLL)
        else $error("table done outside final poll");

endmodule // srs_host_seq
`default_nettype wire

// [tb/srs_dev_model.sv]
// Behavioural model of the serial-link device register map
`timescale 1ns/1ps
`default_nettype none
module srs_dev_model
    import srs_pkg::*;
#(
    parameter int INIT_ENTRIES = 3
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    // Register access from the controller
    input  wire srs_dev_req_s  dev_req,
    output var  logic [DW-1:0] dev_rdata,
    // Port clock presence and entry pacing from the bench
    input  wire logic [31:0]   tx_alive,
    input  wire logic [31:0]   rx_alive,
    input  wire logic [7:0]    step_cyc,
    // Register image for the bench
    output var  logic [DW-1:0] iq_base_q,
    output var  logic [DW-1:0] iq_len_q,
    output var  logic [DW-1:0] ptr_q,
    output var  logic [DW-1:0] len_q,
    output var  logic [15:0]   pend_q,
    output var  logic [15:0]   ack_q
);
    logic [DW-1:0] rd_q;
    logic          vld_q;
    logic [7:0]    tick_q;
    logic [15:0]   idx_q;
    logic [DW-1:0] sel;

    // Read select; pending count sits in the low half of the length register
    always_comb begin
        case (dev_req.addr)
            DEV_IQ_BASE:  sel = iq_base_q;
            DEV_IQ_LEN:   sel = iq_len_q;
            DEV_TX_ALIVE: sel = tx_alive;
            DEV_RX_ALIVE: sel = rx_alive;
            DEV_REQ_PTR:  sel = ptr_q;
            DEV_REQ_LEN:  sel = {16'h0000, pend_q};
            default:      sel = '0;
        endcase
    end

    // Data stands one cycle; later the inverse, so a late sample never matches
    assign dev_rdata = vld_q ? rd_q : ~rd_q;

    // Register writes and entry countdown
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q    <= 16'(INIT_ENTRIES);
            iq_base_q <= '0;
            iq_len_q  <= '0;
            ptr_q     <= '0;
            len_q     <= '0;
            rd_q      <= '0;
            vld_q     <= 1'b0;
            tick_q    <= 8'h00;
            idx_q     <= 16'h0000;
            ack_q     <= 16'h0000;
        end else begin
            vld_q <= dev_req.rd;
            if (dev_req.rd) begin
                rd_q <= sel;
            end
            if (pend_q != 16'h0000) begin
                tick_q <= tick_q + 8'h01;
                if (tick_q >= step_cyc) begin
                    // Entry done: count down, ack if its enable bit is set
                    tick_q <= 8'h00;
                    pend_q <= pend_q - 16'h0001;
                    idx_q  <= idx_q + 16'h0001;
                    if (ptr_q[idx_q[4:0]]) begin
                        ack_q <= ack_q + 16'h0001;
                    end
                end
            end
            if (dev_req.wr) begin
                case (dev_req.addr)
                    DEV_SOFT_RST: begin
                        // Bus settings untouched, device state back to start
                        if (dev_req.wdata == SOFT_RST_VAL) begin
                            pend_q    <= 16'(INIT_ENTRIES);
                            iq_base_q <= '0;
                            iq_len_q  <= '0;
                            idx_q     <= 16'h0000;
                        end
                    end
                    DEV_IQ_BASE: iq_base_q <= dev_req.wdata;
                    DEV_IQ_LEN:  iq_len_q <= dev_req.wdata;
                    DEV_REQ_PTR: ptr_q <= dev_req.wdata;
                    DEV_REQ_LEN: begin
                        // A length written while busy is dropped
                        if (pend_q == 16'h0000) begin
                            len_q  <= dev_req.wdata;
                            pend_q <= dev_req.wdata[15:0];
                            idx_q  <= 16'h0000;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule // srs_dev_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the host-side start-up and request sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import srs_pkg::*;
;
    localparam int WAIT_N = 10;
    logic          core_clk;
    logic          rst_b;
    srs_sw_req_s   sw_req;
    logic [DW-1:0] sw_rdata;
    srs_dev_req_s  dev_req;
    logic [DW-1:0] dev_rdata, iq_base_q, iq_len_q, ptr_q, len_q;
    logic [31:0]   tx_alive, rx_alive;
    logic [7:0]    step_cyc;
    logic [15:0]   pend_q, ack_q;
    logic [DW-1:0] d, v_base, v_iql, v_ptr, v_len;
    int            n_fail, n_tests, n_soft, seed, k;

    srs_host_seq #(.WAIT_CYC(WAIT_N)) uut (.core_clk(core_clk), .rst_b(rst_b),
        .sw_req(sw_req), .sw_rdata(sw_rdata), .dev_req(dev_req), .dev_rdata(dev_rdata));
    srs_dev_model u_dev (.core_clk(core_clk), .rst_b(rst_b), .dev_req(dev_req),
        .dev_rdata(dev_rdata), .tx_alive(tx_alive), .rx_alive(rx_alive),
        .step_cyc(step_cyc), .iq_base_q(iq_base_q), .iq_len_q(iq_len_q),
        .ptr_q(ptr_q), .len_q(len_q), .pend_q(pend_q), .ack_q(ack_q));

    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    function automatic logic [DW-1:0] st_word(logic i, logic t, logic n, logic e);
        return {27'h0, e, n, t, i, 1'b0};
    endfunction

    task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic sw_wr(input logic [SW_AW-1:0] a, input logic [DW-1:0] w);
        @(posedge core_clk);
        sw_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: w};
        @(posedge core_clk);
        sw_req <= '0;
    endtask

    // Read data is taken in the single cycle after the strobe
    task automatic sw_rd(input logic [SW_AW-1:0] a, output logic [DW-1:0] r);
        @(posedge core_clk);
        sw_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: '0};
        @(posedge core_clk);
        sw_req <= '0;
        @(negedge core_clk);
        r = sw_rdata;
        @(posedge core_clk);
    endtask

    // Poll status until busy drops; bounded so a stuck sequencer shows up
    task automatic wait_idle();
        int i;
        d = 32'h1;
        for (i = 0; i < 400 && d[0] !== 1'b0; i++) begin
            sw_rd(R_STATUS, d);
        end
        if (d[0] !== 1'b0) begin
            chk(d, 32'h0);
        end
    endtask

    task automatic wrap_up();
        $display("Checks: %0d  mismatches: %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Device-side monitor: soft resets counted, length only written when idle
    always @(posedge core_clk) begin
        if (dev_req.wr === 1'b1 && dev_req.addr === DEV_SOFT_RST) n_soft++;
        if (dev_req.wr === 1'b1 && dev_req.addr === DEV_REQ_LEN) chk({16'h0, pend_q}, 0);
    end

    // Watchdog sized well past the longest sequence
    initial begin
        repeat (40000) @(posedge core_clk);
        n_fail++;
        wrap_up();
    end

    initial begin
        seed = 32'h0819f099;
        sw_req = '0;
        rst_b = 1'b0;
        tx_alive = 32'hFFFFFFFF;
        rx_alive = 32'hFFFFFFFF;
        step_cyc = 8'h02;
        n_fail = 0;
        n_tests = 0;
        n_soft = 0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        // Quiet after reset, unmapped place reads zero
        sw_rd(R_STATUS, d);
        chk(d, 32'h0);
        sw_rd(8'h40, d);
        chk(d, 32'h0);
        // Queue and mask settings, queue pair read back
        v_base = $random(seed);
        v_iql = $random(seed);
        sw_wr(R_IQ_BASE, v_base);
        sw_wr(R_IQ_LEN, v_iql);
        sw_wr(R_TX_MASK, $random(seed) | 32'h1);
        sw_wr(R_RX_MASK, $random(seed));
        sw_rd(R_IQ_BASE, d);
        chk(d, v_base);
        sw_rd(R_IQ_LEN, d);
        chk(d, v_iql);
        // Start-up with soft reset: wait for pending zero, then queue setup
        sw_wr(R_CTRL, 32'h3);
        wait_idle();
        chk(d & 32'h1B, st_word(1, 0, 0, 0));
        chk(32'(n_soft), 32'h1);
        chk(iq_base_q, v_base);
        chk(iq_len_q, v_iql);
        sw_rd(R_TX_SEEN, d);
        chk(d, 32'hFFFFFFFF);
        sw_rd(R_RX_SEEN, d);
        chk(d, 32'hFFFFFFFF);
        sw_rd(R_CTRL, d);
        chk(d, 32'h2);
        // Start-up without soft reset while a transmit port has no clock
        tx_alive <= 32'h0;
        sw_wr(R_CTRL, 32'h1);
        repeat (80) @(posedge core_clk);
        tx_alive <= 32'hFFFFFFFF;
        wait_idle();
        chk(d & 32'h1B, st_word(1, 0, 1, 0));
        chk(32'(n_soft), 32'h1);
        sw_rd(R_CTRL, d);
        chk(d, 32'h0);
        sw_wr(R_STATUS, 32'h8);
        sw_rd(R_STATUS, d);
        chk(d & 32'h8, 32'h0);
        // Random tables back to back, pacing varied
        for (k = 0; k < 4; k++) begin
            v_ptr = $random(seed);
            v_len = 32'(16'h1 + 16'($random(seed) & 7));
            step_cyc <= 8'($random(seed) & 7);
            sw_wr(R_TBL_PTR, v_ptr);
            sw_wr(R_TBL_LEN, v_len);
            sw_wr(R_CTRL, 32'h4);
            wait_idle();
            chk(d & 32'h15, st_word(0, 1, 0, 0));
            chk(ptr_q, v_ptr);
            chk(len_q, v_len);
            sw_rd(R_PENDING, d);
            chk(d, 32'h0);
        end
        // Orders while busy are refused and flagged
        step_cyc <= 8'h28;
        sw_wr(R_TBL_LEN, 32'h4);
        sw_wr(R_CTRL, 32'h4);
        sw_wr(R_TBL_PTR, ~v_ptr);
        sw_wr(R_CTRL, 32'h4);
        wait_idle();
        chk(d & 32'h14, 32'h14);
        sw_rd(R_TBL_PTR, d);
        chk(d, v_ptr);
        chk(len_q, 32'h4);
        sw_wr(R_STATUS, 32'h10);
        sw_rd(R_STATUS, d);
        chk(d & 32'h10, 32'h0);
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
